// >>> reqc_pkg.sv
// Purpose: shared constants and types for the redriver configuration bank
// Assumes: 50 MHz core clock; serial target pins sampled through synchronisers
// Notes:   strap pads deliver a resolved level code per pin
package reqc_pkg;

  // register offsets
  localparam logic [7:0] GEN_OFS      = 8'h0a;
  localparam logic [7:0] EQ_OFS       = 8'h20;
  localparam logic [7:0] PTR_RST      = 8'h00;

  // edges after release before the strap synchronisers hold pin levels
  localparam logic [1:0] STRAP_WAIT   = 2'h2;

  // values after reset
  localparam logic [7:0] GEN_RST      = 8'h01;
  localparam logic [7:0] EQ_RST       = 8'h00;

  // general register access masks
  localparam logic [7:0] GEN_RW_MASK  = 8'h1f;
  localparam logic [7:0] GEN_SET_MASK = 8'h00;
  localparam logic [7:0] GEN_CLR_MASK = 8'h00;
  localparam logic [7:0] GEN_RO_MASK  = 8'he0;

  // equalization register access masks
  localparam logic [7:0] EQ_RW_MASK   = 8'hff;
  localparam logic [7:0] EQ_SET_MASK  = 8'h00;
  localparam logic [7:0] EQ_CLR_MASK  = 8'h00;

  // general register field positions
  localparam int         LANE_BIT     = 0;
  localparam int         FLIP_BIT     = 2;
  localparam int         EQSRC_BIT    = 4;

  // strap level codes from the pad
  localparam logic [1:0] LVL_LOW      = 2'h0;
  localparam logic [1:0] LVL_FLOAT    = 2'h1;

  // target address = base + 3 * high index + low index
  localparam logic [6:0] ADDR_BASE    = 7'h0e;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  // serial target states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ACK_PEND = 3'b010,
    ST_ACK      = 3'b011,
    ST_WR_BYTE  = 3'b100,
    ST_RD_BYTE  = 3'b101,
    ST_RD_ACK   = 3'b110
  } reqc_state_t;

  // merge a write into a register by field access type
  function automatic logic [7:0] reqc_wmerge(input logic [7:0] old_v, input logic [7:0] wr,
                                             input logic [7:0] rw_m, input logic [7:0] set_m,
                                             input logic [7:0] clr_m);
    reqc_wmerge = ((old_v & ~rw_m) | (wr & rw_m) | (wr & set_m)) & ~(wr & clr_m);
  endfunction

endpackage

// >>> reqc_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   first stage is read only by the second stage
module reqc_sync
  import reqc_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pin side
  input  wire logic [W-1:0] async_i,
  // core side
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta; // first stage, may go metastable
    logic [W-1:0] safe; // second stage, used by logic
  } reqc_sync_s_t;

  reqc_sync_s_t s_q;
  reqc_sync_s_t s_d;

  // shift the pins along the chain
  always_comb begin
    s_d      = s_q;
    s_d.meta = async_i;
    s_d.safe = s_q.meta;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.safe;

endmodule

// >>> reqc_strap.sv
// Purpose: catch strap levels once after reset and derive address and eq
// Assumes: strap inputs are already synchronised
// Notes:   straps are read once; later pin changes are ignored until reset
module reqc_strap
  import reqc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // synchronised strap codes
  input  wire logic [1:0] addr_strap_high,
  input  wire logic [1:0] addr_strap_low,
  input  wire logic [3:0] rx_eq_strap_pins,
  // captured results
  output logic      [6:0] dev_addr,
  output logic      [3:0] eq_strap,
  output logic            strap_done
);

  typedef struct packed {
    logic       done;  // capture has happened
    logic [1:0] wait_n; // edges since release, while the sync chain fills
    logic [6:0] addr;  // decoded target address
    logic [3:0] eq;    // sampled equalization code
  } reqc_strap_s_t;

  reqc_strap_s_t s_q;
  reqc_strap_s_t s_d;

  // map a pad level code to a 0..2 index
  function automatic logic [6:0] lvl_idx(input logic [1:0] c);
    if (c == LVL_LOW) begin
      lvl_idx = 7'h00;
    end else if (c == LVL_FLOAT) begin
      lvl_idx = 7'h01;
    end else begin
      lvl_idx = 7'h02;
    end
  endfunction

  // capture once the sync chain holds pin levels, then hold
  always_comb begin
    s_d = s_q;
    if (!s_q.done) begin
      if (s_q.wait_n != STRAP_WAIT) begin
        // the synchronisers still show their reset zeros; capturing now would read low straps
        s_d.wait_n = s_q.wait_n + 2'h1;
      end else begin
        s_d.done = 1'b1;
        s_d.addr = ADDR_BASE + 7'(3 * lvl_idx(addr_strap_high)) + lvl_idx(addr_strap_low);
        s_d.eq   = rx_eq_strap_pins;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dev_addr   = s_q.addr;
  assign eq_strap   = s_q.eq;
  assign strap_done = s_q.done;

endmodule

// >>> reqc_top.sv
// Purpose: configuration register bank of the redriver mux behind a serial target port
// Assumes: controller does not stretch clock; pads resolve strap levels to codes
// Notes:   open-drain data pin; core samples both bus lines at 50 MHz
//
// Contract
// - floating straps give target address 0x12
// - strap levels select the target address
// - software sets each receiver eq independently
// - set fields: one sets, zero ignored
// - clear fields: one clears, zero ignored
// - hardware-updated fields read current value
// - general reg at 0x0a, reset 0x01
// - bit 4 chooses strap or register eq
// - bit 2 selects flipped orientation
// - bit 0 enables all lanes
// - 0x20 bits 7:4 receiver two eq
// - 0x20 bits 3:0 receiver one eq
// - reads start at offset zero after power-up
// - pointer advances after every read byte
module reqc_top
  import reqc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // serial target pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // strap pins as pad level codes
  input  wire logic [1:0] addr_strap_high,
  input  wire logic [1:0] addr_strap_low,
  input  wire logic [3:0] rx_eq_strap_pins,
  // controls to the analog lanes
  output logic            lane_enable,
  output logic            flip_select,
  output logic            eq_source_select,
  output logic      [3:0] rx1_eq_level,
  output logic      [3:0] rx2_eq_level
);

  // synchronised pins and captured strap results
  logic       scl;        // bus clock line
  logic       sda;        // bus data line
  logic [1:0] strap_hi_s; // address strap, high pin
  logic [1:0] strap_lo_s; // address strap, low pin
  logic [3:0] eq_pins_s;  // equalization straps
  logic [6:0] dev_addr;   // our target address
  logic [3:0] eq_strap;   // captured eq code
  logic       strap_done; // straps valid

  // all pins pass two flops before use
  reqc_sync #(.W(10)) i_reqc_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .async_i ({scl_i, sda_i, addr_strap_high, addr_strap_low, rx_eq_strap_pins}),
    .sync_o  ({scl, sda, strap_hi_s, strap_lo_s, eq_pins_s})
  );

  // strap capture and address decode
  reqc_strap i_reqc_strap (
    .clk              (clk),
    .rst_n            (rst_n),
    .addr_strap_high  (strap_hi_s),
    .addr_strap_low   (strap_lo_s),
    .rx_eq_strap_pins (eq_pins_s),
    .dev_addr         (dev_addr),
    .eq_strap         (eq_strap),
    .strap_done       (strap_done)
  );

  typedef struct packed {
    reqc_state_t st;    // target state
    logic        scl_p; // bus clock last cycle
    logic        sda_p; // bus data last cycle
    logic [7:0]  sh;    // receive shifter
    logic [7:0]  tx;    // transmit shifter
    logic [2:0]  cnt;   // bit count within byte
    logic [7:0]  ptr;   // register pointer
    logic        first; // next written byte is the offset
    logic        rw;    // read transfer
    logic        ack;   // controller acked last read byte
    logic [7:0]  gen;   // general control register
    logic [7:0]  eq;    // rx equalization select register
    logic        oe;    // pulling the data line low
  } reqc_top_s_t;

  reqc_top_s_t s_q;
  reqc_top_s_t s_d;

  // bus events and helpers
  logic       scl_rise; // clock rising
  logic       scl_fall; // clock falling
  logic       start_c;  // start or repeated start
  logic       stop_c;   // stop condition
  logic [7:0] sh_n;     // shifter with the new bit

  // read data by offset; unmapped reads return zero
  function automatic logic [7:0] rd_val(input logic [7:0] ofs, input logic [7:0] g, input logic [7:0] e);
    if (ofs == GEN_OFS) begin
      rd_val = g & ~GEN_RO_MASK;
    end else if (ofs == EQ_OFS) begin
      rd_val = e;
    end else begin
      rd_val = 8'h00;
    end
  endfunction

  // next state: bus decode, byte engine, register file
  always_comb begin
    s_d      = s_q;
    scl_rise = scl & ~s_q.scl_p;
    scl_fall = ~scl & s_q.scl_p;
    start_c  = scl & s_q.scl_p & s_q.sda_p & ~sda;
    stop_c   = scl & s_q.scl_p & ~s_q.sda_p & sda;
    sh_n     = {s_q.sh[6:0], sda};
    s_d.scl_p = scl;
    s_d.sda_p = sda;
    // eq follows straps while not overridden
    if (!s_q.gen[EQSRC_BIT]) begin
      s_d.eq = {eq_strap, eq_strap};
    end
    // start and stop win over the byte engine; straps must be valid first
    if (start_c && strap_done) begin
      s_d.st    = ST_ADDR;
      s_d.cnt   = 3'h0;
      s_d.first = 1'b1;
    end else if (stop_c) begin
      s_d.st = ST_IDLE;
    end else begin
      unique case (s_q.st)
        ST_IDLE: begin
          // wait for a start
        end
        ST_ADDR: begin
          if (scl_rise) begin
            s_d.sh  = sh_n;
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == BIT_LAST) begin
              if (sh_n[7:1] == dev_addr) begin
                s_d.rw = sh_n[0];
                s_d.st = ST_ACK_PEND;
              end else begin
                s_d.st = ST_IDLE;
              end
            end
          end
        end
        ST_ACK_PEND: begin
          // hold the line until clock is low before acking
          if (scl_fall) begin
            s_d.st = ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            s_d.cnt = 3'h0;
            if (s_q.rw) begin
              // pointer is zero after reset; each read byte steps it on
              s_d.tx = rd_val(s_q.ptr, s_q.gen, s_q.eq);
              s_d.st = ST_RD_BYTE;
            end else begin
              s_d.st = ST_WR_BYTE;
            end
          end
        end
        ST_WR_BYTE: begin
          if (scl_rise) begin
            s_d.sh  = sh_n;
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == BIT_LAST) begin
              s_d.first = 1'b0;
              s_d.st    = ST_ACK_PEND;
              if (s_q.first) begin
                s_d.ptr = sh_n;
              end else begin
                s_d.ptr = s_q.ptr + 8'h01;
                if (s_q.ptr == GEN_OFS) begin
                  s_d.gen = reqc_wmerge(s_q.gen, sh_n, GEN_RW_MASK, GEN_SET_MASK, GEN_CLR_MASK);
                end else if (s_q.ptr == EQ_OFS && s_q.gen[EQSRC_BIT]) begin
                  s_d.eq = reqc_wmerge(s_q.eq, sh_n, EQ_RW_MASK, EQ_SET_MASK, EQ_CLR_MASK);
                end
              end
            end
          end
        end
        ST_RD_BYTE: begin
          // each fall ends one bit; eight falls end the byte
          if (scl_fall) begin
            s_d.tx  = {s_q.tx[6:0], 1'b0};
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == BIT_LAST) begin
              s_d.ptr = s_q.ptr + 8'h01;
              s_d.st  = ST_RD_ACK;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            s_d.ack = ~sda;
          end
          if (scl_fall) begin
            if (s_q.ack) begin
              s_d.cnt = 3'h0;
              s_d.tx  = rd_val(s_q.ptr, s_q.gen, s_q.eq);
              s_d.st  = ST_RD_BYTE;
            end else begin
              // a nack ends data; wait for stop or start
              s_d.st = ST_IDLE;
            end
          end
        end
        default: begin
          s_d.st = ST_IDLE;
        end
      endcase
    end
    // drive low only for an ack or a zero data bit
    s_d.oe = (s_d.st == ST_ACK) || (s_d.st == ST_RD_BYTE && !s_d.tx[7]);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.scl_p <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.ptr   <= PTR_RST;
      s_q.gen   <= GEN_RST;
      s_q.eq    <= EQ_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // open drain: only ever pull low
  assign sda_o            = 1'b0;
  assign sda_oe           = s_q.oe;
  assign lane_enable      = s_q.gen[LANE_BIT];
  assign flip_select      = s_q.gen[FLIP_BIT];
  assign eq_source_select = s_q.gen[EQSRC_BIT];
  assign rx2_eq_level     = s_q.eq[7:4];
  assign rx1_eq_level     = s_q.eq[3:0];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_ptr_after_reset: assert property ($rose(rst_n) |-> s_q.ptr == PTR_RST && s_q.gen == GEN_RST)
    else $error("pointer or general reg wrong after reset");
  chk_addr_match: assert property (s_q.st == ST_ADDR && s_d.st == ST_ACK_PEND |-> sh_n[7:1] == dev_addr)
    else $error("acked a foreign address");
  chk_addr_reject: assert property (s_q.st == ST_ADDR && scl_rise && s_q.cnt == BIT_LAST && !start_c && !stop_c
                                    && sh_n[7:1] != dev_addr |=> s_q.st == ST_IDLE)
    else $error("did not drop a foreign address");
  chk_rd_ptr_step: assert property (s_q.st == ST_RD_BYTE && s_d.st == ST_RD_ACK |=> s_q.ptr == $past(s_q.ptr) + 8'h01)
    else $error("pointer did not advance after read byte");
  chk_eq_strap_mode: assert property (!eq_source_select && strap_done |=> rx1_eq_level == eq_strap && rx2_eq_level == eq_strap)
    else $error("eq not following straps");
  chk_eq_hold_ovr: assert property (eq_source_select && $stable(eq_source_select) && s_q.st != ST_WR_BYTE
                                    |=> $stable(s_q.eq))
    else $error("eq changed without a write in override");
  chk_gen_reserved: assert property (s_q.gen[7:5] == 3'h0)
    else $error("reserved general bits set");
  chk_gen_write: assert property (s_q.st == ST_WR_BYTE && s_d.st == ST_ACK_PEND && !s_q.first && s_q.ptr == GEN_OFS
                                  |=> lane_enable == $past(sh_n[LANE_BIT]) && flip_select == $past(sh_n[FLIP_BIT])
                                      && eq_source_select == $past(sh_n[EQSRC_BIT]))
    else $error("general write not applied");
  chk_ack_release: assert property (stop_c |=> !sda_oe)
    else $error("data line held after stop");

  cov_read_byte: cover property (s_q.st == ST_RD_ACK ##1 s_q.st == ST_RD_BYTE);
  cov_gen_write: cover property (s_q.st == ST_WR_BYTE && s_d.st == ST_ACK_PEND && s_q.ptr == GEN_OFS);
  cov_read_nack: cover property (s_q.st == ST_RD_ACK && scl_fall && !s_q.ack);

endmodule

// >>> reqc_ctl_model.sv
// Purpose: serial bus controller model that configures the redriver bank
// Assumes: pulled-up open-drain data line, resolved outside this model
// Notes:   clock idles high between frames; phases are 4 to 8 core cycles
module reqc_ctl_model (
  // core clock for pacing
  input  wire logic clk,
  // bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // wait a number of core edges
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start();
    if (!scl) begin
      sda_low <= 1'b0;
      hold(4);
      scl <= 1'b1;
      hold(8);
    end
    sda_low <= 1'b1;
    hold(8);
    scl <= 1'b0;
    hold(4);
  endtask

  // stop: data rises while the clock is high
  task automatic stop();
    sda_low <= 1'b1;
    hold(4);
    scl <= 1'b1;
    hold(8);
    sda_low <= 1'b0;
    hold(8);
  endtask

  // one bit time; a one releases the line so the target may answer
  task automatic xbit(input logic b, output logic s);
    sda_low <= !b;
    hold(4);
    scl <= 1'b1;
    hold(4);
    s = sda_line;
    hold(4);
    scl <= 1'b0;
    hold(4);
  endtask

  // send a byte msb first, return the ack bit (0 = acked)
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xbit(b[i], s);
    xbit(1'b1, ack);
  endtask

  // take a byte, then ack it or not
  task automatic rbyte(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) xbit(1'b1, b[i]);
    xbit(nack, s);
  endtask
endmodule

// >>> tb_top.sv
// Purpose: register-level test of the redriver configuration bank
// Assumes: straps settle during reset; controller model paces the bus
// Notes:   every access goes over the serial target port
module tb_top
  import reqc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // clock, reset and bus wires
  logic       clk;
  logic       rst_n;
  logic       scl;
  logic       ctl_low;
  logic       sda_w;
  logic       sda_o;
  logic       sda_oe;
  // straps and lane controls
  logic [1:0] strap_hi;
  logic [1:0] strap_lo;
  logic [3:0] eq_pins;
  logic       lane_enable;
  logic       flip_select;
  logic       eq_source_select;
  logic [3:0] rx1_eq_level;
  logic [3:0] rx2_eq_level;
  // bookkeeping
  logic [7:0] rx_buf [16];
  int         miscompares;
  int         n_checks;

  // pulled-up line: low while either party pulls it
  assign sda_w = !(ctl_low || (sda_oe && !sda_o));

  reqc_top i_reqc_top (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_strap_high(strap_hi), .addr_strap_low(strap_lo),
    .rx_eq_strap_pins(eq_pins), .lane_enable(lane_enable), .flip_select(flip_select),
    .eq_source_select(eq_source_select), .rx1_eq_level(rx1_eq_level), .rx2_eq_level(rx2_eq_level));

  reqc_ctl_model i_reqc_ctl_model (.clk(clk), .sda_line(sda_w), .scl(scl), .sda_low(ctl_low));

  // 50 MHz core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // compare one value, report at once
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // counts, verdict and end of run
  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // reset with straps held stable across the release
  task automatic do_reset(input logic [1:0] hi, input logic [1:0] lo);
    @(posedge clk);
    rst_n <= 1'b0;
    strap_hi <= hi;
    strap_lo <= lo;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  // write: address, offset, optional data; a foreign address ends early
  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                    input logic has_d, input logic exp_nack);
    logic ack;
    i_reqc_ctl_model.start();
    i_reqc_ctl_model.wbyte({dev, 1'b0}, ack);
    check({7'h00, ack}, {7'h00, exp_nack});
    if (!ack) begin
      i_reqc_ctl_model.wbyte(ofs, ack);
      check({7'h00, ack}, 8'h00);
      if (has_d) begin
        i_reqc_ctl_model.wbyte(d, ack);
        check({7'h00, ack}, 8'h00);
      end
    end
    i_reqc_ctl_model.stop();
  endtask

  // read n bytes from the current pointer, last one not acked
  task automatic rd(input logic [6:0] dev, input int n);
    logic ack;
    i_reqc_ctl_model.start();
    i_reqc_ctl_model.wbyte({dev, 1'b1}, ack);
    check({7'h00, ack}, 8'h00);
    for (int i = 0; i < n; i++) i_reqc_ctl_model.rbyte(rx_buf[i], i == n - 1);
    i_reqc_ctl_model.stop();
  endtask

  // set the pointer, then read one byte there
  task automatic rd_at(input logic [6:0] dev, input logic [7:0] ofs);
    wr(dev, ofs, 8'h00, 1'b0, 1'b0);
    rd(dev, 1);
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    strap_hi = LVL_FLOAT;
    strap_lo = LVL_FLOAT;
    eq_pins = 4'h5;
    miscompares = 0;
    n_checks = 0;
    do_reset(LVL_FLOAT, LVL_FLOAT);
    // values after reset; eq follows the straps
    check({7'h00, lane_enable}, GEN_RST);
    check({6'h00, eq_source_select, flip_select}, 8'h00);
    check({rx2_eq_level, rx1_eq_level}, 8'h55);
    // first read with no offset runs from zero up to the general register
    rd(7'h12, 11);
    for (int i = 0; i < 10; i++) check(rx_buf[i], 8'h00);
    check(rx_buf[10], GEN_RST);
    // a nacked byte still moves the pointer on
    rd_at(7'h12, 8'h1f);
    check(rx_buf[0], 8'h00);
    rd(7'h12, 1);
    check(rx_buf[0], 8'h55);
    // eq writes are ignored while the straps drive eq
    wr(7'h12, EQ_OFS, 8'h9c, 1'b1, 1'b0);
    rd_at(7'h12, EQ_OFS);
    check(rx_buf[0], 8'h55);
    // reserved bits written as zero
    wr(7'h12, GEN_OFS, 8'h15, 1'b1, 1'b0);
    check({5'h00, eq_source_select, flip_select, lane_enable}, 8'h07);
    rd_at(7'h12, GEN_OFS);
    check(rx_buf[0], 8'h15);
    // register eq per receiver
    wr(7'h12, EQ_OFS, 8'h9c, 1'b1, 1'b0);
    check({4'h0, rx1_eq_level}, 8'h0c);
    check({4'h0, rx2_eq_level}, 8'h09);
    rd_at(7'h12, EQ_OFS);
    check(rx_buf[0], 8'h9c);
    // lanes off, normal orientation, eq back to straps
    wr(7'h12, GEN_OFS, 8'h00, 1'b1, 1'b0);
    check({6'h00, flip_select, lane_enable}, 8'h00);
    check({rx2_eq_level, rx1_eq_level}, 8'h55);
    rd_at(7'h12, EQ_OFS);
    check(rx_buf[0], 8'h55);
    // foreign address is not acked
    wr(7'h13, GEN_OFS, 8'h00, 1'b0, 1'b1);
    // mid-run reset with other straps moves the address
    do_reset(2'h2, LVL_LOW);
    check({7'h00, lane_enable}, 8'h01);
    wr(7'h12, GEN_OFS, 8'h00, 1'b0, 1'b1);
    rd_at(7'h14, GEN_OFS);
    check(rx_buf[0], GEN_RST);
    stop_test();
  end

  // hang guard, well past the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule
